// *** scc_curve.sv ***
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Optional first-order filter smooths sampled input.
// - Flag when input below minimum or above maximum.
// - Flag is a registered output for routing.
// - Lost input holds last valid measured value.
// - Sample once per cycle; 5 ms steps, 150 ms.
// - Output float, floor, ceiling or nearest; float default.
// - Point 1 input settable, 0.00001 step, zero.
// - Each point has its settable scaled output.
// - Extra points enabled singly, up to 18; 20 in all.
// - Received input readable, not writable.
// - Curve output readable at 0.00001 resolution.
// - Maximum limit settable, 0.00001 step, zero.
// - Range check only when enabled; default off.
// - Minimum limit settable, 0.00001 step, zero.
module scc_curve
    import scc_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES,
    parameter int NPTS     = NUM_PTS
) (
    // Clock, reset, enable.
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // Register port.
    input  wire logic [7:0]           addr,
    input  wire logic [DW-1:0]        wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [DW-1:0]        rdata,
    // Measurement front end.
    input  wire logic signed [DW-1:0] meas_in,
    input  wire logic                 meas_ok,
    // Results.
    output logic                      out_of_range,
    output logic signed [DW-1:0]      out_value,
    output logic                      out_valid,
    output logic                      irq
);
    localparam int NW = 2 * DW + 2;  // Product width.
    localparam int AW = 5;
    // Every check at the bottom runs on the block clock and rests during reset.
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!rst_n);

    typedef enum logic [2:0] {S_INIT, S_IDLE, S_RD, S_SCAN, S_DIV, S_RND} scc_st_e;
    scc_st_e st;

    // Settings.
    logic [7:0]           ctrl;     // Filter, range, rounding, shift.
    logic [15:0]          cyc_len;  // Update cycle in 5 ms steps.
    logic signed [DW-1:0] lim_min;  // Lower limit.
    logic signed [DW-1:0] lim_max;  // Upper limit.
    logic [NPTS-1:0]      used;     // Extra point enables.
    logic [NEV-1:0]       status;   // Sticky events.
    logic [NEV-1:0]       irq_en;   // Interrupt enables.
    // Datapath.
    logic signed [DW-1:0] acq;      // Last valid input.
    logic signed [DW-1:0] meas_view;
    logic signed [DW-1:0] filt;
    logic signed [DW-1:0] x0, y0, x1, y1;
    logic                 have;     // First enabled point seen.
    logic [AW-1:0]        idx;
    logic [31:0]          step_cnt;
    logic [15:0]          cyc_cnt;
    logic [6:0]           div_cnt;
    logic [NW-1:0]        quo;
    logic [DW:0]          rem;
    logic [DW:0]          den;
    logic                 neg;
    logic signed [DW-1:0] res;
    logic                 lost_seen;
    logic [2*DW-1:0]      pt_rd;

    // Field decode.
    wire       filt_en  = ctrl[C_FILT];
    wire       range_en = ctrl[C_RANGE];
    wire [1:0] rnd_sel  = ctrl[C_RND+1:C_RND];
    wire [3:0] shift    = ctrl[C_SHIFT+3:C_SHIFT];

    // Bus decode.
    wire          wr_ok   = ce && wr;
    wire [7:0]    pt_off  = addr - A_PT;
    wire          pt_hit  = (addr >= A_PT) && (pt_off < 8'(2 * NPTS));
    wire          pt_wr   = wr_ok && pt_hit && (st != S_INIT);
    wire [AW-1:0] pt_idx  = pt_off[AW:1];

    // Point store writes: defaults during init, else software.
    wire          init    = (st == S_INIT);
    wire          m_we_lo = init || (pt_wr && !pt_off[0]);
    wire          init_fix = init && (idx == 5'(NPTS));
    wire          m_we_hi = (init && !init_fix) || (pt_wr && pt_off[0]);
    wire [AW-1:0] m_waddr = init_fix ? 5'h01 : (init ? idx : pt_idx);
    wire [DW-1:0] m_wdata = init ? (init_fix ? PT2_X_RST : LIM_RST) : wdata;
    // Cycle timing.
    wire step_end = (step_cnt == 32'(STEP_CYC - 1));
    wire cyc_end  = ({1'b0, cyc_cnt} + 17'h00001) >= {1'b0, cyc_len};
    wire tick     = ce && (st == S_IDLE) && step_end && cyc_end;

    // Scan view of the point being read.
    wire signed [DW-1:0] px = pt_rd[DW-1:0];
    wire signed [DW-1:0] py = pt_rd[2*DW-1:DW];
    wire pt_used = (idx < 5'h02) || used[idx];
    wire last_pt = (idx == 5'(NPTS - 1));

    // Interpolation operands.
    wire signed [DW:0] dy = {y1[DW-1], y1} - {y0[DW-1], y0};
    wire signed [DW:0] dx = {filt[DW-1], filt} - {x0[DW-1], x0};
    wire signed [DW:0] dd = {x1[DW-1], x1} - {x0[DW-1], x0};
    wire signed [NW-1:0] prod = NW'(dy) * NW'(dx);
    wire [NW-1:0] prod_abs = prod[NW-1] ? NW'(-prod) : NW'(prod);
    wire [DW:0]   dd_abs   = dd[DW] ? (DW+1)'(-dd) : (DW+1)'(dd);

    // One divider step: shift in a numerator bit, subtract if it fits.
    wire [DW+1:0] rem_sh  = {rem, quo[NW-1]};
    wire          fits    = rem_sh >= {1'b0, den};
    wire [DW+1:0] rem_sub = rem_sh - {1'b0, den};
    wire [DW-1:0] q_mag   = quo[DW-1:0];
    wire signed [DW-1:0] interp = y0 + (neg ? DW'(-q_mag) : DW'(q_mag));

    // Rounding helpers on the interpolated value.
    wire signed [DW-1:0] r_mod  = res % SCALE;
    wire signed [DW-1:0] r_base = res - r_mod;
    wire signed [DW-1:0] r_flr  = r_mod[DW-1] ? (r_base - SCALE) : r_base;
    wire signed [DW-1:0] r_cel  = (r_mod > 0) ? (r_base + SCALE) : r_base;
    wire signed [DW-1:0] n_val  = res + HALF;
    wire signed [DW-1:0] n_mod  = n_val % SCALE;
    wire signed [DW-1:0] n_base = n_val - n_mod;
    wire signed [DW-1:0] r_near = n_mod[DW-1] ? (n_base - SCALE) : n_base;
    wire signed [DW-1:0] rounded = (rnd_sel == RND_FLOOR) ? r_flr :
                                   (rnd_sel == RND_CEIL)  ? r_cel :
                                   (rnd_sel == RND_NEAR)  ? r_near : res;
    // Range check on the input of this cycle.
    wire next_oor  = range_en && ((acq < lim_min) || (acq > lim_max));
    // Events; a set beats a clear in the same cycle.
    wire [NEV-1:0] ev;
    assign ev[ST_OOR]  = tick && next_oor && !out_of_range;
    assign ev[ST_DONE] = ce && (st == S_RND);
    assign ev[ST_LOST] = tick && lost_seen;
    wire [NEV-1:0] clr = (wr_ok && addr == A_ICLR) ? wdata[NEV-1:0] : '0;
    wire [NEV-1:0] next_status = (status & ~clr) | ev;

    // Read mux; point words read as zero.
    wire [DW-1:0] rd_mux =
        (addr == A_CTRL)  ? DW'(ctrl) :
        (addr == A_CYCLE) ? DW'(cyc_len) :
        (addr == A_MIN)   ? lim_min :
        (addr == A_MAX)   ? lim_max :
        (addr == A_USED)  ? DW'(used | NPTS'(3)) :
        (addr == A_MEAS)  ? meas_view :
        (addr == A_OUT)   ? out_value :
        (addr == A_STAT)  ? DW'(status) :
        (addr == A_IEN)   ? DW'(irq_en) : '0;

    // Setting registers; none of the indications is writable.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl    <= CTRL_RST;
            cyc_len <= CYCLE_RST;
            lim_min <= LIM_RST;
            lim_max <= LIM_RST;
            used    <= '0;
            irq_en  <= '0;
        end else if (wr_ok) begin
            if (addr == A_CTRL)  ctrl    <= wdata[7:0];
            if (addr == A_CYCLE) cyc_len <= wdata[15:0];
            if (addr == A_MIN)   lim_min <= wdata;
            if (addr == A_MAX)   lim_max <= wdata;
            if (addr == A_USED)  used    <= wdata[NPTS-1:0];
            if (addr == A_IEN)   irq_en  <= wdata[NEV-1:0];
        end
    end

    // Read data, status and interrupt, all registered.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata  <= '0;
            status <= '0;
            irq    <= 1'b0;
        end else if (ce) begin
            rdata  <= rd ? rd_mux : '0;
            status <= next_status;
            irq    <= |(next_status & irq_en);
        end
    end

    // Keep the last valid sample; a loss leaves it untouched.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acq       <= '0;
            lost_seen <= 1'b0;
        end else if (ce) begin
            if (meas_ok) begin
                acq <= meas_in;
            end
            lost_seen <= tick ? !meas_ok : (lost_seen || !meas_ok);
        end
    end

    // Step and cycle counters; they wait while a result is computed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_cnt <= '0;
            cyc_cnt  <= '0;
        end else if (ce && st == S_IDLE) begin
            step_cnt <= step_end ? '0 : step_cnt + 32'h0000_0001;
            if (step_end) begin
                cyc_cnt <= cyc_end ? '0 : cyc_cnt + 16'h0001;
            end
        end
    end

    // Sample, filter, scan, divide, round.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st           <= S_INIT;
            idx          <= '0;
            filt         <= '0;
            meas_view    <= '0;
            out_of_range <= 1'b0;
            out_value    <= '0;
            out_valid    <= 1'b0;
            {x0, y0, x1, y1} <= '0;
            have         <= 1'b0;
            div_cnt      <= '0;
            quo          <= '0;
            rem          <= '0;
            den          <= '0;
            neg          <= 1'b0;
            res          <= '0;
        end else if (ce) begin
            out_valid <= 1'b0;
            unique case (st)
                // Zero all points, then point 2 input 1.0 alone: one data port.
                S_INIT: begin
                    idx <= idx + 5'h01;
                    if (init_fix) begin
                        idx <= '0;
                        st  <= S_IDLE;
                    end
                end
                // Once per cycle take the sample and update the filter.
                S_IDLE: begin
                    if (tick) begin
                        meas_view    <= acq;
                        out_of_range <= next_oor;
                        // Gain 2^-shift; a larger shift is a longer time constant.
                        filt <= filt_en ? filt + ((acq - filt) >>> shift) : acq;
                        have <= 1'b0;
                        idx  <= '0;
                        st   <= S_RD;
                    end
                end
                // Address a point; data arrive next cycle.
                S_RD: begin
                    st <= S_SCAN;
                end
                // Track the last two enabled points and stop at the segment.
                S_SCAN: begin
                    st  <= S_RD;
                    idx <= idx + 5'h01;
                    if (pt_used) begin
                        x1   <= px;
                        y1   <= py;
                        have <= 1'b1;
                        if (have) begin
                            x0 <= x1;
                            y0 <= y1;
                        end
                        if (have && filt <= px) begin
                            st <= S_DIV;
                        end
                    end
                    // Beyond the last point, extend the last segment.
                    if (last_pt) begin
                        st <= S_DIV;
                    end
                    div_cnt <= '0;
                end
                // Restoring divide of (dy*dx) by the segment width.
                S_DIV: begin
                    if (div_cnt == 7'h00) begin
                        quo <= prod_abs;
                        rem <= '0;
                        den <= dd_abs;
                        neg <= prod[NW-1] ^ dd[DW];
                        div_cnt <= 7'h01;
                    end else if (div_cnt <= 7'(NW)) begin
                        rem <= fits ? rem_sub[DW:0] : rem_sh[DW:0];
                        quo <= {quo[NW-2:0], fits};
                        div_cnt <= div_cnt + 7'h01;
                    end else begin
                        // All quotient bits are in; a zero-width segment gives its first output.
                        res <= (dd == '0) ? y0 : interp;
                        st  <= S_RND;
                    end
                end
                // Round as selected and publish.
                S_RND: begin
                    out_value <= rounded;
                    out_valid <= 1'b1;
                    st        <= S_IDLE;
                end
            endcase
        end
    end

    // Point store.
    scc_pt_mem #(.HW(DW), .DEPTH(NPTS), .AW(AW)) u_mem (
        .clk   (clk),
        .ce    (ce),
        .we_lo (m_we_lo),
        .we_hi (m_we_hi),
        .waddr (m_waddr),
        .wdata (m_wdata),
        .raddr (idx),
        .rdata (pt_rd)
    );

    // Checks.
    sequence s_tick;
        tick;
    endsequence
    sequence s_done;
        out_valid;
    endsequence
    property p_oor_low;
        tick && range_en && acq < lim_min |=> out_of_range;
    endproperty
    a_oor_low: assert property (p_oor_low) else $error("flag missed low input");
    property p_oor_off;
        tick && !range_en |=> !out_of_range;
    endproperty
    a_oor_off: assert property (p_oor_off) else $error("flag set while disabled");
    property p_oor_back;
        tick && acq >= lim_min && acq <= lim_max |=> !out_of_range;
    endproperty
    a_oor_back: assert property (p_oor_back) else $error("flag stuck in range");
    property p_hold;
        !meas_ok |=> acq == $past(acq);
    endproperty
    a_hold: assert property (p_hold) else $error("held value changed");
    property p_nofilt;
        tick && !filt_en |=> filt == $past(acq);
    endproperty
    a_nofilt: assert property (p_nofilt) else $error("unfiltered path wrong");
    property p_result;
        s_tick |-> ##[3:160] s_done;
    endproperty
    a_result: assert property (p_result) else $error("no result after sample");
    // The form used is the one set while rounding, one cycle before the pulse.
    property p_round;
        out_valid && $past(rnd_sel) != RND_FLOAT |-> (out_value % SCALE) == 0;
    endproperty
    a_round: assert property (p_round) else $error("integer form not whole");
    property p_out_read;
        ce && rd && addr == A_OUT ##1 ce |-> rdata == $past(out_value);
    endproperty
    a_out_read: assert property (p_out_read) else $error("output readback wrong");
    property p_meas_read;
        ce && rd && addr == A_MEAS |=> !ce || rdata == $past(meas_view);
    endproperty
    a_meas_read: assert property (p_meas_read) else $error("input readback wrong");
endmodule

// *** scc_pkg.sv ***
package scc_pkg;
    // Value width; values count in units of 0.00001.
    localparam int DW = 48;
    localparam logic signed [47:0] SCALE = 48'h0000_0001_86A0;
    localparam logic signed [47:0] HALF  = 48'h0000_0000_C350;
    // Curve points and a default of 1.0 for point 2.
    localparam int NUM_PTS = 20;
    localparam logic signed [47:0] PT2_X_RST = SCALE;
    // Register offsets.
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_CYCLE = 8'h01;
    localparam logic [7:0] A_MIN   = 8'h02;
    localparam logic [7:0] A_MAX   = 8'h03;
    localparam logic [7:0] A_USED  = 8'h04;
    localparam logic [7:0] A_MEAS  = 8'h05;
    localparam logic [7:0] A_OUT   = 8'h06;
    localparam logic [7:0] A_STAT  = 8'h07;
    localparam logic [7:0] A_ICLR  = 8'h08;
    localparam logic [7:0] A_IEN   = 8'h09;
    localparam logic [7:0] A_PT    = 8'h20;
    // Control fields and reset values.
    localparam int C_FILT  = 0;
    localparam int C_RANGE = 1;
    localparam int C_RND   = 2;
    localparam int C_SHIFT = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic signed [47:0] LIM_RST = 48'h0000_0000_0000;
    // Status and interrupt bits.
    localparam int ST_OOR  = 0;
    localparam int ST_DONE = 1;
    localparam int ST_LOST = 2;
    localparam int NEV     = 3;
    // Timing: update cycle counted in 5 ms steps.
    localparam int CLK_NS       = 10;
    localparam int STEP_MS      = 5;
    localparam int STEP_CYCLES  = STEP_MS * 1000000 / CLK_NS;
    localparam int CYCLE_MS_RST = 150;
    localparam logic [15:0] CYCLE_RST = 16'(CYCLE_MS_RST / STEP_MS);
    // Output rounding forms.
    typedef enum logic [1:0] {RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAR} scc_rnd_e;
endpackage

// *** scc_pt_mem.sv ***
`timescale 1ns/1ps
// Curve point store: each word holds {y, x}; halves are written apart.
module scc_pt_mem #(
    parameter int HW    = 48,
    parameter int DEPTH = 20,
    parameter int AW    = 5
) (
    // Clock.
    input  wire logic            clk,
    input  wire logic            ce,
    // Write port.
    input  wire logic            we_lo,
    input  wire logic            we_hi,
    input  wire logic [AW-1:0]   waddr,
    input  wire logic [HW-1:0]   wdata,
    // Read port, one cycle latency.
    input  wire logic [AW-1:0]   raddr,
    output logic      [2*HW-1:0] rdata
);
    // The array has no reset; the owner loads defaults after reset.
    logic [2*HW-1:0] mem [DEPTH];

    // Writes touch only the selected half.
    always_ff @(posedge clk) begin
        if (ce && we_lo) begin
            mem[waddr][HW-1:0] <= wdata;
        end
        if (ce && we_hi) begin
            mem[waddr][2*HW-1:HW] <= wdata;
        end
    end

    // Read data always come from a register.
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// *** scc_front.sv ***
`timescale 1ns/1ps
// Behavioural model of the measurement front end feeding the curve block.
module scc_front
    import scc_pkg::*;
(
    // Clock.
    input  wire logic                 clk,
    // Bench control: level to present and a lost-signal request.
    input  wire logic signed [DW-1:0] level,
    input  wire logic                 lose,
    // Measurement outputs towards the block.
    output logic signed [DW-1:0]      meas_in,
    output logic                      meas_ok
);
    // Last value shown while the signal was good.
    logic signed [DW-1:0] last;

    // Remember the good value so a lost signal can show its inverse.
    always_ff @(posedge clk) begin
        if (!lose) begin
            last <= level;
        end
    end

    // A lost line shows the inverse so that stale data is never mistaken for a sample.
    assign meas_in = lose ? ~last : level;
    assign meas_ok = !lose;
endmodule

// *** tb_scaled_input_curve.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
// Self-checking bench: drivers note expectations, a monitor compares them.
module tb_scaled_input_curve
    import scc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, lose = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [DW-1:0] wdata = 48'h0, rdata, re;
    logic signed [DW-1:0] meas_in, out_value, level = 48'sh0;
    logic meas_ok, out_of_range, out_valid, irq;
    logic [DW:0] ev;
    logic [15:0] lf = 16'h0012;
    logic [DW-1:0] rq[$];
    logic [DW:0] eq[$];
    int fail_count = 0, total_checks = 0;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    // Short update step keeps the run brief; expectations do not depend on it.
    scc_curve #(.STEP_CYC(4), .NPTS(NUM_PTS)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas_in(meas_in),
        .meas_ok(meas_ok), .out_of_range(out_of_range), .out_value(out_value),
        .out_valid(out_valid), .irq(irq));
    scc_front FE (.clk(clk), .level(level), .lose(lose), .meas_in(meas_in), .meas_ok(meas_ok));

    // Pseudo-random source for input levels.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected rounding of a positive value to whole units.
    function automatic logic signed [47:0] rnd(input logic signed [47:0] v, input int m);
        logic signed [47:0] f;
        f = v - v % SCALE;
        case (m)
            1: return f;
            2: return (f == v) ? v : f + SCALE;
            3: return (v - f >= HALF) ? f + SCALE : f;
            default: return v;
        endcase
    endfunction

    // One-cycle register write.
    task automatic wreg(input logic [7:0] a, input logic [47:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle register read; the expected data is noted for the monitor.
    task automatic rreg(input logic [7:0] a, input logic [47:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(d);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Present a new input level, or a lost signal.
    task automatic set_in(input logic signed [47:0] v, input logic l);
        @(posedge clk);
        level <= v;
        lose <= l;
    endtask

    // Bounded wait for the next result pulse, sampled mid-cycle.
    task automatic wait_valid();
        int n;
        n = 0;
        @(negedge clk);
        while (out_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1000) fail_count++;
    endtask

    // Skip results that may still use old settings, then expect the next one.
    task automatic settle(input logic f, input logic signed [47:0] v);
        wait_valid();
        wait_valid();
        @(negedge clk);
        eq.push_back({f, v});
        wait_valid();
        @(negedge clk);
    endtask

    // Monitor: read data one cycle after a read, results on each pulse that has an expectation queued.
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) begin
            re = rq.pop_front();
            `CHK("rdata", re, rdata)
        end
        if (out_valid === 1'b1 && eq.size() > 0) begin
            ev = eq.pop_front();
            `CHK("out_value", ev[DW-1:0], out_value)
            `CHK("out_of_range", ev[DW], out_of_range)
        end
    end

    // Print the counts and the verdict, then stop.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog sized well above the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        rreg(A_CTRL, 48'h0);
        rreg(A_CYCLE, 48'h1E);
        rreg(A_MIN, 48'h0);
        rreg(A_MAX, 48'h0);
        rreg(A_USED, 48'h3);
        rreg(8'h10, 48'h0);
        rreg(A_PT, 48'h0);
        set_in(48'sd50000, 1'b0);
        settle(1'b0, 48'sh0);
        // Two-point line from (0,0) to (1.0,3.0), then random levels on it.
        wreg(A_CYCLE, 48'h1);
        wreg(A_PT + 8'h03, 48'd300000);
        settle(1'b0, 48'sd150000);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            set_in({32'h0, lf}, 1'b0);
            settle(1'b0, 3 * $signed({32'h0, lf}));
            rreg(A_MEAS, {32'h0, lf});
            rreg(A_OUT, 3 * {32'h0, lf});
        end
        // Every rounding form at a value just below and exactly at a half.
        for (int l = 0; l < 2; l++) begin
            set_in(48'sd49999 + l, 1'b0);
            for (int m = 0; m < 4; m++) begin
                wreg(A_CTRL, 48'(m << C_RND));
                settle(1'b0, rnd(48'sd149997 + 3 * l, m));
            end
        end
        wreg(A_CTRL, 48'h0);
        // Lost input keeps the last good sample.
        set_in(48'sd50000, 1'b0);
        settle(1'b0, 48'sd150000);
        set_in(48'sd90000, 1'b1);
        settle(1'b0, 48'sd150000);
        rreg(A_MEAS, 48'd50000);
        // Range check: off by default, then above and below the limits.
        wreg(A_MIN, 48'd20000);
        wreg(A_MAX, 48'd80000);
        wreg(A_IEN, 48'h1);
        set_in(48'sd90000, 1'b0);
        settle(1'b0, 48'sd270000);
        wreg(A_CTRL, 48'h2);
        settle(1'b1, 48'sd270000);
        `CHK("irq", 1'b1, irq)
        wreg(A_ICLR, 48'h1);
        repeat (2) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        set_in(48'sd10000, 1'b0);
        settle(1'b1, 48'sd30000);
        set_in(48'sd50000, 1'b0);
        settle(1'b0, 48'sd150000);
        // Third point at (2.0,10.0) turns the line into a user curve.
        wreg(A_CTRL, 48'h0);
        wreg(A_PT + 8'h04, 48'd200000);
        wreg(A_PT + 8'h05, 48'd1000000);
        wreg(A_USED, 48'h7);
        rreg(A_USED, 48'h7);
        set_in(48'sd150000, 1'b0);
        settle(1'b0, 48'sd650000);
        // Filter gain one half: a time constant of two updates, twice the one-update
        // step it smooths. A step of 4 then settles one unit short, at 1.50003.
        wreg(A_CTRL, 48'h11);
        set_in(48'sd150004, 1'b0);
        settle(1'b0, 48'sd650021);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
